// file: hdl/decode_cfg.svh
// constants for the accumulator move and return decoder
`ifndef DECODE_CFG_SVH
`define DECODE_CFG_SVH

// ----------------------------------------------------------------
// opcode encodings (14-bit instruction words)
// ----------------------------------------------------------------
`define STORE_ACC_HI     7'h01
`define STORE_ACC_HI_POS 7
`define IDLE_HI          7'h00
`define IDLE_LO_MASK     14'h001f
`define INT_RETURN_OP    14'h0009
`define OPTION_LOAD_OP   14'h0062

// ----------------------------------------------------------------
// register positions and reset values
// ----------------------------------------------------------------
`define GIE_BIT          7
`define OPTION_FILE_ADDR 7'h01
`define IRQCTL_FILE_ADDR 7'h0b
`define OPTION_RESET     8'hff
`define GIE_RESET        1'b0

// ----------------------------------------------------------------
// timing in instruction cycles
// ----------------------------------------------------------------
`define RETURN_CYCLES    2
`define SINGLE_CYCLES    1

`endif

// file: hdl/decode_pkg.sv
// types shared by the decoder modules
package decode_pkg;
  // execution phase of the decoder
  typedef enum logic [0:0] {
    ST_EXEC,
    ST_FLUSH
  } exec_state_t;

  // one-hot class of the current opcode
  typedef struct packed {
    logic store_accumulator_op;
    logic idle_op;
    logic interrupt_return_op;
    logic option_load_op;
    logic other_op;
  } op_class_t;
endpackage

// file: hdl/decode_if.sv
// carrier between the opcode classifier and the executing core
`timescale 1ns/10ps
`default_nettype none
interface decode_if;
  import decode_pkg::*;
  logic [13:0] opcode;      // instruction word under decode
  op_class_t   op_class;    // resulting class
  logic [6:0]  file_addr;   // direct file address field

  modport classifier (input opcode, output op_class, output file_addr);
  modport core (output opcode, input op_class, input file_addr);
endinterface // decode_if
`default_nettype wire

// file: hdl/opcode_classifier.sv
// combinational classifier of the four handled opcodes
`timescale 1ns/10ps
`default_nettype none
`include "decode_cfg.svh"
module opcode_classifier
  import decode_pkg::*;
(
  decode_if.classifier dif
);
  // ----------------------------------------------------------------
  // match logic
  // ----------------------------------------------------------------
  // no-operation ignores the two middle bits, so match by mask
  always_comb begin
    dif.op_class.store_accumulator_op =
      (dif.opcode[13:`STORE_ACC_HI_POS] == `STORE_ACC_HI);
    dif.op_class.idle_op =
      (dif.opcode[13:`STORE_ACC_HI_POS] == `IDLE_HI) &&
      ((dif.opcode & `IDLE_LO_MASK) == 14'h0000);
    dif.op_class.interrupt_return_op = (dif.opcode == `INT_RETURN_OP);
    dif.op_class.option_load_op      = (dif.opcode == `OPTION_LOAD_OP);
    dif.op_class.other_op = !(dif.op_class.store_accumulator_op ||
                              dif.op_class.idle_op ||
                              dif.op_class.interrupt_return_op ||
                              dif.op_class.option_load_op);
    dif.file_addr = dif.opcode[6:0];
  end
endmodule // opcode_classifier
`default_nettype wire

// file: hdl/accumulator_move_return_decode.sv
// decode and execute for store, idle, interrupt return and option load
// What this block does
// - store accumulator to 7-bit file address, one cycle
// - interrupt return pops stack, loads program counter
// - interrupt return sets global interrupt enable bit
// - interrupt return takes two instruction cycles
// - legacy load writes accumulator into option register
// - option register stays ordinary file register
`timescale 1ns/10ps
`default_nettype none
`include "decode_cfg.svh"
module accumulator_move_return_decode
  import decode_pkg::*;
(
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_srst,
  // instruction stream, one word per instruction cycle
  input  wire logic        i_instr_valid,
  input  wire logic [13:0] i_instr,
  // core state read by the block
  input  wire logic [7:0]  i_accum,
  input  wire logic [12:0] i_stack_top,
  input  wire logic        i_irq_entry,
  // file register write port
  output logic             o_file_we,
  output logic [6:0]       o_file_addr,
  output logic [7:0]       o_file_wdata,
  // program flow
  output logic             o_pc_advance,
  output logic             o_pc_load,
  output logic [12:0]      o_pc_value,
  output logic             o_stack_pop,
  output logic             o_ready,
  output logic             o_unhandled,
  // registers held here
  output logic [7:0]       o_option_reg,
  output logic             o_global_irq_enable,
  output logic             o_status_we
);
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  decode_if    dif ();                    // classifier carrier
  exec_state_t state_reg;                 // execution phase
  logic        accept;                    // instruction taken now
  op_class_t   cls;                       // class of taken word

  assign dif.opcode = i_instr;
  assign cls        = dif.op_class;
  // a word offered during the flush cycle is not taken
  assign accept = i_instr_valid && (state_reg == ST_EXEC);

  opcode_classifier opcode_classifier_inst (
    .dif (dif.classifier)
  );

  // ----------------------------------------------------------------
  // phase machine
  // ----------------------------------------------------------------
  // the second cycle of a return only lets the refetch settle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_reg <= ST_EXEC;
    end else begin
      unique case (state_reg)
        ST_EXEC: begin
          if (accept && cls.interrupt_return_op) begin
            state_reg <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          state_reg <= ST_EXEC;
        end
      endcase
    end
  end

  // ready drops for exactly the flush cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_ready <= 1'b1;
    end else if (state_reg == ST_FLUSH) begin
      o_ready <= 1'b1;
    end else begin
      o_ready <= !(accept && cls.interrupt_return_op);
    end
  end

  // ----------------------------------------------------------------
  // file write port
  // ----------------------------------------------------------------
  // store and legacy load both show on the write port so that the
  // register file copy of the option register stays coherent
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_file_we    <= 1'b0;
      o_file_addr  <= 7'h00;
      o_file_wdata <= 8'h00;
    end else begin
      o_file_we <= accept &&
                   (cls.store_accumulator_op || cls.option_load_op);
      if (accept && cls.store_accumulator_op) begin
        o_file_addr  <= dif.file_addr;
        o_file_wdata <= i_accum;
      end else if (accept && cls.option_load_op) begin
        o_file_addr  <= `OPTION_FILE_ADDR;
        o_file_wdata <= i_accum;
      end
    end
  end

  // none of the four handled opcodes touches a status flag
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_status_we <= 1'b0;
    end else begin
      o_status_we <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // program flow
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pc_advance <= 1'b0;
      o_pc_load    <= 1'b0;
      o_stack_pop  <= 1'b0;
      o_pc_value   <= 13'h0000;
      o_unhandled  <= 1'b0;
    end else begin
      // single-cycle words step the counter by one
      o_pc_advance <= accept && (cls.idle_op || cls.store_accumulator_op ||
                                 cls.option_load_op);
      o_pc_load    <= accept && cls.interrupt_return_op;
      o_stack_pop  <= accept && cls.interrupt_return_op;
      if (accept && cls.interrupt_return_op) begin
        o_pc_value <= i_stack_top;
      end
      // other opcodes belong to neighbouring decoders
      o_unhandled  <= accept && cls.other_op;
    end
  end

  // ----------------------------------------------------------------
  // option register
  // ----------------------------------------------------------------
  // written by the legacy load and by a direct store alike; software
  // should prefer the direct store, the legacy path is kept only for
  // old code
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_option_reg <= `OPTION_RESET;
    end else if (accept && cls.option_load_op) begin
      o_option_reg <= i_accum;
    end else if (accept && cls.store_accumulator_op &&
                 dif.file_addr == `OPTION_FILE_ADDR) begin
      o_option_reg <= i_accum;
    end
  end

  // ----------------------------------------------------------------
  // global interrupt enable
  // ----------------------------------------------------------------
  // a return in the same cycle as interrupt entry wins, so the enable
  // is never lost
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_global_irq_enable <= `GIE_RESET;
    end else if (accept && cls.interrupt_return_op) begin
      o_global_irq_enable <= 1'b1;
    end else if (accept && cls.store_accumulator_op &&
                 dif.file_addr == `IRQCTL_FILE_ADDR) begin
      o_global_irq_enable <= i_accum[`GIE_BIT];
    end else if (i_irq_entry) begin
      o_global_irq_enable <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  a_store_write: assert property (
    accept && cls.store_accumulator_op |=>
      o_file_we && o_file_addr == $past(i_instr[6:0]) &&
      o_file_wdata == $past(i_accum))
    else $error("store did not write accumulator to file address");

  a_return_pop: assert property (
    accept && cls.interrupt_return_op |=>
      o_pc_load && o_stack_pop && o_pc_value == $past(i_stack_top))
    else $error("return did not pop and load program counter");

  a_return_gie: assert property (
    accept && cls.interrupt_return_op |=> o_global_irq_enable)
    else $error("return did not set interrupt enable");

  a_return_two: assert property (
    accept && cls.interrupt_return_op |=> !o_ready ##1 o_ready)
    else $error("return did not occupy two cycles");

  a_flush_noaccept: assert property (
    state_reg == ST_FLUSH |=> !o_file_we && !o_pc_advance && !o_pc_load)
    else $error("word taken during return flush cycle");

  a_option_load: assert property (
    accept && cls.option_load_op |=>
      o_option_reg == $past(i_accum) && o_file_we &&
      o_file_addr == `OPTION_FILE_ADDR)
    else $error("legacy load did not write option register");

  a_option_direct: assert property (
    accept && cls.store_accumulator_op &&
    i_instr[6:0] == `OPTION_FILE_ADDR |=> o_option_reg == $past(i_accum))
    else $error("direct store missed option register");

  // an entry pulse in the same cycle clears the enable on its own
  a_idle_quiet: assert property (
    accept && cls.idle_op && !i_irq_entry |=>
      o_pc_advance && !o_file_we && !o_pc_load && !o_stack_pop &&
      $stable(o_option_reg) && $stable(o_global_irq_enable))
    else $error("idle changed state or failed to advance");

  a_no_status: assert property (
    !o_status_we)
    else $error("status write raised by handled opcode");

  c_store: cover property (accept && cls.store_accumulator_op);
  c_return: cover property (accept && cls.interrupt_return_op ##2 accept);
  c_option: cover property (accept && cls.option_load_op);
  c_idle: cover property (accept && cls.idle_op ##1 accept && cls.idle_op);
endmodule // accumulator_move_return_decode
`default_nettype wire

// file: sim/test_accumulator_move_return_decode.sv
// self-checking random bench for the move, idle, return and option decoder
`timescale 1ns/10ps
`default_nettype none
module test_accumulator_move_return_decode;
  import decode_pkg::*;
  // ------------------------------------------------------------
  // design signals
  // ------------------------------------------------------------
  logic        i_ref_clk;           // 50 MHz clock
  logic        i_srst;              // synchronous reset
  logic        i_instr_valid;       // word offered
  logic [13:0] i_instr;             // instruction word
  logic [7:0]  i_accum;             // accumulator
  logic [12:0] i_stack_top;         // stack top
  logic        i_irq_entry;         // interrupt entry pulse
  logic        o_file_we, o_pc_advance, o_pc_load, o_stack_pop;
  logic        o_ready, o_unhandled, o_global_irq_enable, o_status_we;
  logic [6:0]  o_file_addr;
  logic [7:0]  o_file_wdata, o_option_reg;
  logic [12:0] o_pc_value;
  // ------------------------------------------------------------
  // bench state
  // ------------------------------------------------------------
  int          seed = 89662;        // fixed seed, repeatable runs
  int          error_cnt = 0;       // mismatches seen
  int          checks = 0;          // comparisons made
  logic [7:0]  opt_m;               // expected option register
  logic        en_m;                // expected interrupt enable
  logic [31:0] r;                   // random draw
  logic [13:0] w;                   // word under test

  accumulator_move_return_decode accumulator_move_return_decode_inst (
    .i_ref_clk, .i_srst, .i_instr_valid, .i_instr, .i_accum, .i_stack_top,
    .i_irq_entry, .o_file_we, .o_file_addr, .o_file_wdata, .o_pc_advance,
    .o_pc_load, .o_pc_value, .o_stack_pop, .o_ready, .o_unhandled,
    .o_option_reg, .o_global_irq_enable, .o_status_we
  );

  // free-running clock, 20 ns period
  initial begin
    i_ref_clk = 1'b0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // compare with case inequality so an unknown never matches
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  // idle words differ only in the two don't-care bits
  function automatic logic is_idle(input logic [13:0] x);
    return (x & ~14'h0060) == 14'h0000;
  endfunction

  // valid is left high so back-to-back words need no dead cycle
  task automatic issue(input logic [13:0] x, input logic [7:0] a,
                       input logic [12:0] t);
    i_instr_valid = 1'b1;
    i_instr = x;
    i_accum = a;
    i_stack_top = t;
    @(posedge i_ref_clk);
    #1;
  endtask

  // drop valid and let one edge pass
  task automatic gap();
    i_instr_valid = 1'b0;
    @(posedge i_ref_clk);
    #1;
  endtask

  // offer one word and compare every output with the bench model
  task automatic run(input logic [13:0] x, input logic [7:0] a,
                     input logic [12:0] t);
    logic st, ret, opl, idl;
    st = (x[13:7] == 7'h01);
    ret = (x == 14'h0009);
    opl = (x == 14'h0062);
    idl = is_idle(x);
    issue(x, a, t);
    if ((st && x[6:0] == 7'h01) || opl)
      opt_m = a;
    if (st && x[6:0] == 7'h0b)
      en_m = a[7];
    if (ret)
      en_m = 1'b1;
    check(o_file_we, st | opl, "file strobe");
    if (st | opl) begin
      check(o_file_addr, opl ? 7'h01 : x[6:0], "file addr");
      check(o_file_wdata, a, "file data");
    end
    check(o_pc_advance, st | opl | idl, "advance");
    check({o_pc_load, o_stack_pop, o_ready}, {ret, ret, ~ret}, "flow");
    if (ret)
      check(o_pc_value, t, "pc value");
    check(o_unhandled, !(st | opl | idl | ret), "unhandled");
    check(o_option_reg, opt_m, "option");
    check(o_global_irq_enable, en_m, "enable");
    check(o_status_we, 1'b0, "flags");
    // a store offered in the flush cycle must be dropped
    if (ret) begin
      i_instr = 14'h0091;
      @(posedge i_ref_clk);
      #1;
      check({o_file_we, o_pc_load, o_ready}, 3'b001, "flush");
    end
  endtask

  // one verdict for every way the run can end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, 50k cycles, far beyond the planned run
  initial begin
    #1000000;
    error_cnt++;
    summarize();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    i_srst = 1'b1;
    i_instr_valid = 1'b0;
    i_instr = 14'h0000;
    i_accum = 8'h00;
    i_stack_top = 13'h0000;
    i_irq_entry = 1'b0;
    opt_m = 8'hff;
    en_m = 1'b0;
    repeat (4) @(posedge i_ref_clk);
    #1;
    i_srst = 1'b0;
    check(o_option_reg, 8'hff, "option reset");
    check({o_global_irq_enable, o_ready}, 2'b01, "reset state");
    $display("test reset done");
    // all four idle encodings, back to back
    for (int k = 0; k < 4; k++)
      run(14'(k * 32), 8'h5a, 13'h0abc);
    $display("test idle done");
    // legacy load then direct store to the same register
    run(14'h0062, 8'h4f, 13'h0000);
    run(14'h0081, 8'h3c, 13'h0000);
    run(14'h00ff, 8'h00, 13'h0000);
    $display("test option done");
    // enable set by return, cleared by entry, then written by store
    run(14'h0009, 8'h11, 13'h1fff);
    gap();
    i_irq_entry = 1'b1;
    @(posedge i_ref_clk);
    #1;
    i_irq_entry = 1'b0;
    en_m = 1'b0;
    check(o_global_irq_enable, 1'b0, "entry clear");
    run(14'h008b, 8'h80, 13'h0000);
    run(14'h008b, 8'h7f, 13'h0000);
    run(14'h0009, 8'h22, 13'h0000);
    run(14'h0008, 8'h33, 13'h0123);
    run(14'h3fff, 8'h44, 13'h0123);
    $display("test return done");
    // random mix of every class
    repeat (300) begin
      r = $random(seed);
      case (r[2:0])
        3'h0, 3'h1: w = {7'h01, r[14:8]};
        3'h2: w = {7'h00, r[9:8], 5'h00};
        3'h3: w = 14'h0062;
        3'h4: w = 14'h0009;
        default: w = r[29:16];
      endcase
      run(w, 8'($random(seed)), 13'($random(seed)));
    end
    gap();
    $display("test random done");
    // reset again in mid-run: every output back to its idle value
    i_srst = 1'b1;
    repeat (2) @(posedge i_ref_clk);
    #1;
    i_srst = 1'b0;
    opt_m = 8'hff;
    en_m = 1'b0;
    check(o_option_reg, 8'hff, "mid option");
    check({o_global_irq_enable, o_ready}, 2'b01, "mid enable");
    check({o_file_we, o_pc_load, o_stack_pop}, 3'h0, "mid strobes");
    check({o_pc_advance, o_unhandled}, 2'h0, "mid flow");
    check({o_file_addr, o_file_wdata}, 15'h0000, "mid port");
    check(o_pc_value, 13'h0000, "mid pc");
    // words are taken again right after the release
    run(14'h0062, 8'ha5, 13'h0000);
    run(14'h0009, 8'h01, 13'h0555);
    gap();
    $display("test mid reset done");
    summarize();
  end
endmodule // test_accumulator_move_return_decode
`default_nettype wire
